// [tb.sv]
// random bench for the handshake reservation block
// assumes the block and the host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_wr16 = 1'b0, reg_bit_wr = 1'b0;
  logic        setup_done = 1'b0, tok = 1'b0, dat = 1'b0, rc = 1'b0, rp, token_eop, data_eop, hsk_send;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, a, wd;
  logic [2:0]  reg_bit_sel = 3'h0, op, sel, ec = 3'h0, ep;
  logic [13:0] cond = 14'h0000, chk, c;
  logic [7:0]  reg_rdata, m = 8'h00, cand, er = 8'h00, erp;
  logic [31:0] lfsr = 32'h5b070658, w, v;
  int          error_cnt = 0, compares = 0;
  uhr_pkg::uhr_hsk_t hsk_kind;
  always #4 clk_sys = ~clk_sys;
  uhr_host_model host (.tok, .dat, .cond, .token_eop, .data_eop, .chk);
  uhr_hsk_rsv dut (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_wr16, .reg_bit_wr, .reg_bit_sel,
    .reg_wdata, .reg_rdata, .token_eop, .data_eop, .setup_done, .in_token_seen(chk[0]),
    .out_token_seen(chk[1]), .address_match(chk[2]), .token_pid_match(chk[3]),
    .endpoint1_detect(chk[4]), .endpoint0_detect(chk[5]), .token_length_error(chk[6]),
    .token_stuff_error(chk[7]), .token_crc_error(chk[8]), .data_pid_match(chk[9]),
    .data_length_error(chk[10]), .data_stuff_error(chk[11]), .data_crc_error(chk[12]),
    .receive_write_error(chk[13]), .hsk_send, .hsk_kind);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // software never reserves the data NAK with ACK or a data STALL, nor a STALL with the NAK of the same endpoint
  function automatic logic [7:0] leg(input logic [7:0] r);
    if (r[1])
      r = r & 8'hce;
    if (r[7])
      r[3] = 1'b0;
    if (r[6])
      r[2] = 1'b0;
    return r;
  endfunction
  // returns {send, kind}
  function automatic logic [2:0] hx(input logic [7:0] r, input logic t, d, input logic [13:0] q);
    logic g, st, nk, ak;
    g = q[0] & q[2] & ~q[6] & ~q[7] & ~q[8];
    st = t ? r[7] & g & q[4] | r[6] & g & q[3] & q[5] : d & ~q[11] & (r[5] & q[9] & q[10] | r[4] & ~q[9]);
    nk = t ? r[3] & g & q[4] | r[2] & g & q[3] & ~q[5] : d & r[1] & q[1] & q[9] & ~|q[13:10];
    ak = ~t & d & r[0] & q[9] & ~|q[12:10];
    return st ? 3'h7 : nk ? 3'h6 : ak ? 3'h5 : 3'h0;
  endfunction
  task automatic chk8(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 30000; i++)
    begin
      @(posedge clk_sys);
      ep = ec;
      rp = rc;
      erp = er;
      lfsr = nxt(lfsr);
      w = nxt(lfsr);
      v = nxt(w);
      op = lfsr[2:0];
      sel = lfsr[7:5];
      a = lfsr[3] ? 16'hff14 : lfsr[4] ? 16'hff15 : lfsr[31:16];
      c = w[29:16] & (v[13:0] | ~14'h39c0);
      wd = {leg(w[15:8]), leg(w[7:0])};
      cand = m;
      cand[sel] = wd[0];
      wd[0] = wd[0] & (op != 3'h3 || leg(cand) == cand);
      cand[sel] = wd[0];
      ec = hx(m, op == 3'h4, op == 3'h5, c);
      if (op == 3'h6)
        m = 8'h00;
      else if (op == 3'h1 && a == 16'hff14)
        m = wd[7:0];
      else if (op == 3'h2 && a == 16'hff15)
        m = wd[15:8];
      else if (op == 3'h3 && a == 16'hff14)
        m = cand;
      rc = op == 3'h0 || op == 3'h4 || op == 3'h5 || op == 3'h7;
      er = (a == 16'hff14) ? m : 8'h00;
      reg_addr <= a;
      reg_wdata <= wd;
      reg_bit_sel <= sel;
      reg_wr <= op == 3'h1;
      reg_wr16 <= op == 3'h2;
      reg_bit_wr <= op == 3'h3;
      tok <= op == 3'h4;
      dat <= op == 3'h5;
      setup_done <= op == 3'h6;
      cond <= c;
      @(negedge clk_sys);
      chk8({7'h00, hsk_send}, {7'h00, ep[2]});
      chk8({6'h00, hsk_kind}, {6'h00, ep[1:0]});
      if (rp)
        chk8(reg_rdata, erp);
    end
    close_out();
  end
endmodule
`default_nettype wire

// [uhr_consts.svh]
// constants for the handshake transmit reservation block
// assumes inclusion by the block file only
`ifndef UHR_CONSTS_SVH
`define UHR_CONSTS_SVH
`define UHR_ADDR_HSK      16'hff14
`define UHR_ADDR_DATA     16'hff15
`define UHR_RESET_VAL     8'h00
`define UHR_BIT_ACK       3'h0
`define UHR_BIT_NAK_DATA  3'h1
`define UHR_BIT_NAK_EP0   3'h2
`define UHR_BIT_NAK_EP1   3'h3
`define UHR_BIT_STL_DATA  3'h4
`define UHR_BIT_STL_LEN   3'h5
`define UHR_BIT_STL_EP0   3'h6
`define UHR_BIT_STL_EP1   3'h7
`define UHR_SEL_ACK_ONLY  8'h01
`define UHR_SEL_NAK_DATA  8'h02
`endif

// [uhr_host_model.sv]
// host side model: packet end pulses with receive check levels
// assumes the bench asks for at most one packet per cycle
`timescale 1ns/100ps
`default_nettype none
module uhr_host_model
(
  input  wire logic        tok,
  input  wire logic        dat,
  input  wire logic [13:0] cond,
  output logic             token_eop,
  output logic             data_eop,
  output logic      [13:0] chk
);
  assign token_eop = tok;
  assign data_eop = dat & ~tok;
  // levels are only valid at eop, so show their inverse elsewhere
  assign chk = (tok | dat) ? cond : ~cond;
endmodule
`default_nettype wire

// [uhr_hsk_rsv.sv]
// handshake transmit reservation register and handshake selection
// assumes receive checkers on clk_sys give stable condition levels with eop pulses
// Function
// - handshakes only after a good IN token or a received data packet
// - bit 0 ACK, bits 1-3 NAK, bits 4-7 STALL
// - byte, single-bit and 16-bit combined-word writes accepted
// - reset clears the register to 00h
// - a valid SETUP reception clears the register to 00h
// - bit 7 sends STALL after good IN token to endpoint 1
// - bit 6 sends STALL after good IN token with PID match, endpoint 0
// - bit 5 sends STALL after data with PID match and length error, no stuff error
// - bit 4 sends STALL after data with PID mismatch, no stuff error
// - bit 3 sends NAK after good IN token to endpoint 1
// - bit 2 sends NAK after good IN token with PID match, endpoint 0 detect printed zero
// - bit 1 sends NAK after clean OUT data without write error
// - bit 0 sends ACK after clean data packet with PID match
// - a cleared flag never yields its handshake
`timescale 1ns/100ps
`default_nettype none
`include "uhr_consts.svh"
module uhr_hsk_rsv
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_wr16,
  input  wire logic        reg_bit_wr,
  input  wire logic [2:0]  reg_bit_sel,
  input  wire logic [15:0] reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        token_eop,
  input  wire logic        data_eop,
  input  wire logic        setup_done,
  input  wire logic        in_token_seen,
  input  wire logic        out_token_seen,
  input  wire logic        address_match,
  input  wire logic        token_pid_match,
  input  wire logic        endpoint1_detect,
  input  wire logic        endpoint0_detect,
  input  wire logic        token_length_error,
  input  wire logic        token_stuff_error,
  input  wire logic        token_crc_error,
  input  wire logic        data_pid_match,
  input  wire logic        data_length_error,
  input  wire logic        data_stuff_error,
  input  wire logic        data_crc_error,
  input  wire logic        receive_write_error,
  output logic             hsk_send,
  output var uhr_pkg::uhr_hsk_t hsk_kind
);
  logic [7:0] handshake_tx_reservation;
  logic       tok_ok;
  logic       in_ep1;
  logic       in_ep0;
  logic       in_ep0_nak;
  logic       dat_clean;
  uhr_pkg::uhr_hsk_t next_kind;

  // combined word: low byte is the data reservation, high byte this register
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      handshake_tx_reservation <= `UHR_RESET_VAL;
    else if (setup_done)
      handshake_tx_reservation <= `UHR_RESET_VAL;
    else if (reg_wr16 && reg_addr == `UHR_ADDR_DATA)
      handshake_tx_reservation <= reg_wdata[15:8];
    else if (reg_wr && reg_addr == `UHR_ADDR_HSK)
      handshake_tx_reservation <= reg_wdata[7:0];
    else if (reg_bit_wr && reg_addr == `UHR_ADDR_HSK)
      handshake_tx_reservation[reg_bit_sel] <= reg_wdata[0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      reg_rdata <= `UHR_RESET_VAL;
    else if (reg_addr == `UHR_ADDR_HSK)
      reg_rdata <= handshake_tx_reservation;
    else
      reg_rdata <= `UHR_RESET_VAL;
  end

  // receive check results are only meaningful at the eop strobes
  always_comb
  begin
    tok_ok     = in_token_seen && address_match && !token_length_error
                 && !token_stuff_error && !token_crc_error;
    in_ep1     = tok_ok && endpoint1_detect;
    in_ep0     = tok_ok && token_pid_match && endpoint0_detect;
    // endpoint 0 detect taken as printed (zero) for the NAK case
    in_ep0_nak = tok_ok && token_pid_match && !endpoint0_detect;
    dat_clean  = data_pid_match && !data_length_error && !data_stuff_error && !data_crc_error;
    next_kind  = uhr_pkg::UHR_HSK_NONE;
    // flag positions fixed by the bit macros
    if (token_eop)
    begin
      if ((handshake_tx_reservation[`UHR_BIT_STL_EP1] && in_ep1)
          || (handshake_tx_reservation[`UHR_BIT_STL_EP0] && in_ep0))
        next_kind = uhr_pkg::UHR_HSK_STALL;
      else if ((handshake_tx_reservation[`UHR_BIT_NAK_EP1] && in_ep1)
               || (handshake_tx_reservation[`UHR_BIT_NAK_EP0] && in_ep0_nak))
        next_kind = uhr_pkg::UHR_HSK_NAK;
    end
    else if (data_eop)
    begin
      // stall first: a conflicting reservation is software's fault anyway
      if ((handshake_tx_reservation[`UHR_BIT_STL_LEN] && data_pid_match && data_length_error
           && !data_stuff_error)
          || (handshake_tx_reservation[`UHR_BIT_STL_DATA] && !data_pid_match
              && !data_stuff_error))
        next_kind = uhr_pkg::UHR_HSK_STALL;
      else if (handshake_tx_reservation[`UHR_BIT_NAK_DATA] && out_token_seen && dat_clean
               && !receive_write_error)
        next_kind = uhr_pkg::UHR_HSK_NAK;
      else if (handshake_tx_reservation[`UHR_BIT_ACK] && dat_clean)
        next_kind = uhr_pkg::UHR_HSK_ACK;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hsk_send <= 1'b0;
      hsk_kind <= uhr_pkg::UHR_HSK_NONE;
    end
    else
    begin
      hsk_send <= (next_kind != uhr_pkg::UHR_HSK_NONE);
      hsk_kind <= next_kind;
    end
  end

  AST_STALL_EP1: assert property (@(posedge clk_sys) disable iff (!rstn)
    token_eop && handshake_tx_reservation[`UHR_BIT_STL_EP1] && in_ep1
    |=> hsk_send && hsk_kind == uhr_pkg::UHR_HSK_STALL)
    else $error("ep1 stall missing");
  AST_STALL_EP0: assert property (@(posedge clk_sys) disable iff (!rstn)
    token_eop && handshake_tx_reservation[`UHR_BIT_STL_EP0] && in_ep0
    |=> hsk_kind == uhr_pkg::UHR_HSK_STALL)
    else $error("ep0 stall missing");
  AST_ACK: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation == `UHR_SEL_ACK_ONLY && dat_clean
    |=> hsk_kind == uhr_pkg::UHR_HSK_ACK)
    else $error("ack missing");
  AST_NO_FLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
    handshake_tx_reservation == `UHR_RESET_VAL |=> !hsk_send)
    else $error("handshake without reservation");
  AST_NO_EVENT: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && !data_eop |=> !hsk_send)
    else $error("handshake without eop");
  AST_SETUP_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    setup_done |=> handshake_tx_reservation == `UHR_RESET_VAL)
    else $error("setup did not clear");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    !setup_done && !reg_wr && !reg_wr16 && !reg_bit_wr |=> $stable(handshake_tx_reservation))
    else $error("flags changed unasked");
  AST_NAK_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation == `UHR_SEL_NAK_DATA && out_token_seen && dat_clean
    && !receive_write_error |=> hsk_kind == uhr_pkg::UHR_HSK_NAK)
    else $error("data nak missing");
  AST_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_addr == `UHR_ADDR_HSK |=> reg_rdata == $past(handshake_tx_reservation))
    else $error("read mismatch");
  // no disable here: the reset itself is what is checked
  AST_RESET_CLR: assert property (@(posedge clk_sys)
    !rstn
    |=> handshake_tx_reservation == `UHR_RESET_VAL && !hsk_send)
    else $error("reset did not clear");
  AST_STALL_LEN: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation[`UHR_BIT_STL_LEN] && data_pid_match && data_length_error
    && !data_stuff_error |=> hsk_send && hsk_kind == uhr_pkg::UHR_HSK_STALL)
    else $error("length stall missing");
  AST_STALL_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation[`UHR_BIT_STL_DATA] && !data_pid_match
    && !data_stuff_error |=> hsk_send && hsk_kind == uhr_pkg::UHR_HSK_STALL)
    else $error("data stall missing");
  AST_NAK_EP1: assert property (@(posedge clk_sys) disable iff (!rstn)
    token_eop && handshake_tx_reservation[`UHR_BIT_NAK_EP1] && !handshake_tx_reservation[`UHR_BIT_STL_EP1]
    && !handshake_tx_reservation[`UHR_BIT_STL_EP0] && in_ep1 |=> hsk_kind == uhr_pkg::UHR_HSK_NAK)
    else $error("ep1 nak missing");
  AST_NAK_EP0: assert property (@(posedge clk_sys) disable iff (!rstn)
    token_eop && handshake_tx_reservation[`UHR_BIT_NAK_EP0] && !handshake_tx_reservation[`UHR_BIT_STL_EP1]
    && !handshake_tx_reservation[`UHR_BIT_STL_EP0] && in_ep0_nak |=> hsk_kind == uhr_pkg::UHR_HSK_NAK)
    else $error("ep0 nak missing");
  AST_NAK_WRERR: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation == `UHR_SEL_NAK_DATA && receive_write_error
    |=> !hsk_send)
    else $error("data nak despite write error");
  AST_ACK_DIRTY: assert property (@(posedge clk_sys) disable iff (!rstn)
    !token_eop && data_eop && handshake_tx_reservation == `UHR_SEL_ACK_ONLY && !dat_clean
    |=> !hsk_send)
    else $error("ack after faulty data");
  AST_BAD_TOKEN: assert property (@(posedge clk_sys) disable iff (!rstn)
    token_eop && !tok_ok
    |=> !hsk_send)
    else $error("handshake after faulty token");
  AST_ACK_BIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    hsk_kind == uhr_pkg::UHR_HSK_ACK
    |-> $past(handshake_tx_reservation[`UHR_BIT_ACK]))
    else $error("ack without its flag");
  AST_WR16: assert property (@(posedge clk_sys) disable iff (!rstn)
    !setup_done && reg_wr16 && reg_addr == `UHR_ADDR_DATA
    |=> handshake_tx_reservation == $past(reg_wdata[15:8]))
    else $error("word write lost");
  AST_WR8: assert property (@(posedge clk_sys) disable iff (!rstn)
    !setup_done && !reg_wr16 && reg_wr && reg_addr == `UHR_ADDR_HSK
    |=> handshake_tx_reservation == $past(reg_wdata[7:0]))
    else $error("byte write lost");
  AST_BITWR: assert property (@(posedge clk_sys) disable iff (!rstn)
    !setup_done && !reg_wr16 && !reg_wr && reg_bit_wr && reg_addr == `UHR_ADDR_HSK
    |=> handshake_tx_reservation[$past(reg_bit_sel)] == $past(reg_wdata[0]))
    else $error("bit write lost");
  COV_STALL: cover property (@(posedge clk_sys) hsk_kind == uhr_pkg::UHR_HSK_STALL);
  COV_NAK: cover property (@(posedge clk_sys) hsk_kind == uhr_pkg::UHR_HSK_NAK);
  COV_ACK: cover property (@(posedge clk_sys) hsk_kind == uhr_pkg::UHR_HSK_ACK);
  COV_WR16: cover property (@(posedge clk_sys) reg_wr16 && reg_addr == `UHR_ADDR_DATA);
endmodule
`default_nettype wire

// [uhr_pkg.sv]
// types for the handshake transmit reservation block
// assumes no surroundings
package uhr_pkg;
  typedef enum logic [1:0]
  {
    UHR_HSK_NONE  = 2'b00,
    UHR_HSK_ACK   = 2'b01,
    UHR_HSK_NAK   = 2'b10,
    UHR_HSK_STALL = 2'b11
  } uhr_hsk_t;
endpackage
